/* File: core/slg_symbol_loop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slg_consts.svh"
module slg_symbol_loop
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hold_wr,
  input wire logic [1:0] i_hold_idx,
  input wire logic [7:0] i_hold_byte,
  input wire logic i_dest_wr,
  input wire logic [7:0] i_dest_addr,
  input wire logic i_track_mode,
  input wire slg_pkg::slg_err_type i_err,
  input wire slg_pkg::slg_limit_type i_limit,
  output logic [31:0] o_acq_gain_reg,
  output logic [31:0] o_trk_gain_reg,
  output logic o_lag_load_pending,
  output logic o_lag_load_done,
  output logic o_calc_busy,
  output logic [`SLG_LAG_WIDTH-1:0] o_lag_acc,
  output logic [31:0] o_nco_word,
  output logic o_nco_valid
);
  import slg_pkg::*;

  logic [7:0] hold_reg [4];
  logic [7:0] hold_next [4];
  slg_gain_type acq_reg;
  slg_gain_type acq_next;
  slg_gain_type trk_reg;
  slg_gain_type trk_next;
  logic pending_reg;
  logic pending_next;
  logic done_reg;
  logic done_next;
  logic [31:0] hold_word;
  logic lag_req;

  slg_state_type state_reg;
  slg_state_type state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic signed [15:0] err_reg;
  logic signed [15:0] err_next;
  slg_gain_type gain_act_reg;
  slg_gain_type gain_act_next;
  logic [`SLG_LAG_WIDTH-1:0] lag_reg;
  logic [`SLG_LAG_WIDTH-1:0] lag_next;
  logic [31:0] nco_reg;
  logic [31:0] nco_next;
  logic nco_valid_reg;
  logic nco_valid_next;
  logic calc_start;
  logic signed [`SLG_SUM_WIDTH-1:0] lead_term;
  logic signed [`SLG_SUM_WIDTH-1:0] lag_term;
  logic signed [`SLG_SUM_WIDTH-1:0] lag_sum;
  logic [`SLG_LAG_WIDTH-1:0] lag_new;

  localparam logic [2:0] LAST_CNT = 3'(`SLG_COMPUTE_CYCLES - 1);

  // Clamps the running sum to the programmed limits, clearing the fraction bits only when it clamps.
  function automatic logic [`SLG_LAG_WIDTH-1:0] lag_clamp(
    input logic signed [`SLG_SUM_WIDTH-1:0] sum,
    input slg_limit_type lim);
    logic signed [`SLG_SUM_WIDTH-9:0] top;
    top = sum[`SLG_SUM_WIDTH-1:`SLG_LAG_FRAC_BITS];
    if (top > 40'(lim.upper))
    begin
      lag_clamp = {lim.upper, 8'h00};
    end
    else if (top < 40'(lim.lower))
    begin
      lag_clamp = {lim.lower, 8'h00};
    end
    else
    begin
      lag_clamp = sum[`SLG_LAG_WIDTH-1:0];
    end
  endfunction

  slg_gain_scale
  #(
    .ERR_W(16),
    .OUT_W(`SLG_SUM_WIDTH),
    .FRAC_SHIFT(`SLG_LEAD_FRAC_SHIFT)
  )
  u_lead_scale
  (
    .i_err(err_reg),
    .i_mant(gain_act_reg.lead_mant),
    .i_exp(gain_act_reg.lead_exp),
    .o_term(lead_term)
  );

  slg_gain_scale
  #(
    .ERR_W(16),
    .OUT_W(`SLG_SUM_WIDTH),
    .FRAC_SHIFT(`SLG_LAG_FRAC_SHIFT)
  )
  u_lag_scale
  (
    .i_err(err_reg),
    .i_mant(gain_act_reg.lag_mant),
    .i_exp(gain_act_reg.lag_exp),
    .o_term(lag_term)
  );

  assign hold_word = {hold_reg[3], hold_reg[2], hold_reg[1], hold_reg[0]};
  assign calc_start = (state_reg == SLG_IDLE) && i_err.valid;

  // Holding registers, gain registers and the lag load request.
  always_comb
  begin
    hold_next = hold_reg;
    acq_next = acq_reg;
    trk_next = trk_reg;
    pending_next = pending_reg;
    done_next = done_reg;
    lag_req = 1'b0;
    if (i_hold_wr)
    begin
      hold_next[i_hold_idx] = i_hold_byte;
    end
    if (i_dest_wr)
    begin
      case (i_dest_addr)
        // Only bits 17 to 0 are kept; the rest are dropped.
        `SLG_ADDR_GAIN_ACQ: acq_next = hold_word[`SLG_GAIN_FIELD_MSB:0];
        `SLG_ADDR_GAIN_TRK: trk_next = hold_word[`SLG_GAIN_FIELD_MSB:0];
        `SLG_ADDR_LAG_INIT: lag_req = 1'b1;
        default: lag_req = 1'b0;
      endcase
    end
    if (lag_req)
    begin
      pending_next = 1'b1;
      done_next = 1'b0;
    end
    // The load completing wins over a clear in the same cycle.
    if (calc_start && pending_reg)
    begin
      pending_next = lag_req;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_reg <= '{default: `SLG_HOLD_RESET};
      acq_reg <= `SLG_GAIN_RESET;
      trk_reg <= `SLG_GAIN_RESET;
      pending_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      acq_reg <= acq_next;
      trk_reg <= trk_next;
      pending_reg <= pending_next;
      done_reg <= done_next;
    end
  end

  // Loop filter compute cycle.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    err_next = err_reg;
    gain_act_next = gain_act_reg;
    lag_next = lag_reg;
    nco_next = nco_reg;
    nco_valid_next = 1'b0;
    lag_sum = $signed({{8{lag_reg[`SLG_LAG_WIDTH-1]}}, lag_reg}) + lag_term;
    lag_new = lag_clamp(lag_sum, i_limit);
    case (state_reg)
      SLG_IDLE:
      begin
        if (i_err.valid)
        begin
          state_next = SLG_CALC;
          cnt_next = 3'h0;
          err_next = i_err.value;
          gain_act_next = i_track_mode ? trk_reg : acq_reg;
          if (pending_reg)
          begin
            // For the lag load, holding registers are sampled only here, at the cycle start.
            lag_next = {hold_word, 8'h00};
          end
        end
      end
      SLG_CALC:
      begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == LAST_CNT)
        begin
          state_next = SLG_IDLE;
          lag_next = lag_new;
          nco_next = lag_new[`SLG_LAG_WIDTH-1:`SLG_LAG_FRAC_BITS] + lead_term[31:0];
          nco_valid_next = 1'b1;
        end
      end
      default:
      begin
        state_next = SLG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= SLG_IDLE;
      cnt_reg <= 3'h0;
      err_reg <= 16'sh0000;
      gain_act_reg <= `SLG_GAIN_RESET;
      lag_reg <= 40'h00_0000_0000;
      nco_reg <= 32'h0000_0000;
      nco_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      err_reg <= err_next;
      gain_act_reg <= gain_act_next;
      lag_reg <= lag_next;
      nco_reg <= nco_next;
      nco_valid_reg <= nco_valid_next;
    end
  end

  assign o_acq_gain_reg = {14'h0000, acq_reg};
  assign o_trk_gain_reg = {14'h0000, trk_reg};
  assign o_lag_load_pending = pending_reg;
  assign o_lag_load_done = done_reg;
  assign o_calc_busy = (state_reg == SLG_CALC);
  assign o_lag_acc = lag_reg;
  assign o_nco_word = nco_reg;
  assign o_nco_valid = nco_valid_reg;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_busy_eight;
    (state_reg == SLG_CALC) [*8];
  endsequence

  sequence s_back_idle;
    (state_reg == SLG_IDLE) && nco_valid_reg;
  endsequence

  a_calc_length: assert property (calc_start |=> s_busy_eight ##1 s_back_idle)
    else $error("Compute cycle did not take eight clocks.");

  a_lag_load_value: assert property (calc_start && pending_reg |=>
    lag_reg == {$past(hold_word), 8'h00})
    else $error("Lag accumulator not loaded from holding word.");

  a_load_done_flag: assert property (calc_start && pending_reg && !lag_req |=>
    done_reg && !pending_reg)
    else $error("Load completion status not shown.");

  a_load_waits_start: assert property (pending_reg && !calc_start |=>
    pending_reg && !done_reg)
    else $error("Lag load left pending state without a compute start.");

  a_gain_select: assert property (calc_start |=>
    gain_act_reg == ($past(i_track_mode) ? $past(trk_reg) : $past(acq_reg)))
    else $error("Wrong gain set selected for the mode.");

  a_acq_gain_write: assert property (i_dest_wr && i_dest_addr == `SLG_ADDR_GAIN_ACQ |=>
    o_acq_gain_reg == {14'h0000, $past(hold_word[`SLG_GAIN_FIELD_MSB:0])})
    else $error("Acquisition gain write not stored.");

  a_trk_gain_write: assert property (i_dest_wr && i_dest_addr == `SLG_ADDR_GAIN_TRK |=>
    o_trk_gain_reg == {14'h0000, $past(hold_word[`SLG_GAIN_FIELD_MSB:0])})
    else $error("Track gain write not stored.");

  a_lag_in_limits: assert property (nco_valid_reg && $stable(i_limit) &&
    (i_limit.upper >= i_limit.lower) |->
    ($signed(lag_reg[39:8]) <= i_limit.upper) && ($signed(lag_reg[39:8]) >= i_limit.lower))
    else $error("Lag accumulator outside the programmed limits.");

endmodule // slg_symbol_loop
`default_nettype wire

/* File: core/slg_consts.svh */
// Contract
// - Lead mantissa is four fraction bits under an implied one, bit 17 highest.
// - Lead exponent E scales by two to the minus (32 minus E); the code scales by two to the minus (16 minus E).
// - Lag mantissa decodes like the lead mantissa, bit 8 highest.
// - Lag exponent decodes like the lead exponent, bit 4 highest; the code scales by two to the minus (8 minus E).
// - Track gain register has the same field layout at its own address.
// - Lag init write loads the accumulator at the next compute cycle start.
// - A readable status shows when the pending lag load has completed.
// - Holding word goes to the upper 32 bits; the low 8 bits clear.
// - At slow rates the load may wait up to one symbol period.
// - Each loop filter output takes eight clock cycles to compute.
// - Lag accumulator is 40 bits, clamped to limits with low bits cleared.
`ifndef SLG_CONSTS_SVH
`define SLG_CONSTS_SVH

`define SLG_ADDR_GAIN_ACQ 8'h11
`define SLG_ADDR_GAIN_TRK 8'h12
`define SLG_ADDR_LAG_INIT 8'h13

`define SLG_GAIN_FIELD_MSB 17
`define SLG_GAIN_RESET 18'h00000
`define SLG_HOLD_RESET 8'h00

`define SLG_COMPUTE_CYCLES 8
`define SLG_LAG_WIDTH 40
`define SLG_LAG_FRAC_BITS 8
`define SLG_SUM_WIDTH 48
`define SLG_LEAD_FRAC_SHIFT 20
`define SLG_LAG_FRAC_SHIFT 12

`endif

/* File: core/slg_pkg.sv */
`default_nettype none
package slg_pkg;

  // Gain register bits 17 down to 0.
  typedef struct packed
  {
    logic [3:0] lead_mant;
    logic [4:0] lead_exp;
    logic [3:0] lag_mant;
    logic [4:0] lag_exp;
  } slg_gain_type;

  typedef struct packed
  {
    logic valid;
    logic signed [15:0] value;
  } slg_err_type;

  typedef struct packed
  {
    logic signed [31:0] upper;
    logic signed [31:0] lower;
  } slg_limit_type;

  typedef enum logic [0:0]
  {
    SLG_IDLE = 1'b0,
    SLG_CALC = 1'b1
  } slg_state_type;

endpackage
`default_nettype wire

/* File: core/slg_gain_scale.sv */
`timescale 1ns/1ps
`default_nettype none
module slg_gain_scale
#(
  parameter int ERR_W = 16,
  parameter int OUT_W = 48,
  parameter int FRAC_SHIFT = 12
)
(
  input wire logic signed [ERR_W-1:0] i_err,
  input wire logic [3:0] i_mant,
  input wire logic [4:0] i_exp,
  output logic signed [OUT_W-1:0] o_term
);

  logic signed [ERR_W+5:0] prod;
  logic signed [OUT_W-1:0] prod_ext;
  logic [5:0] exp_ext;
  logic [5:0] frac_shift;

  always_comb
  begin
    // The mantissa is one point four fraction bits, so it is sixteen plus the field.
    prod = i_err * $signed({2'b01, i_mant});
    prod_ext = OUT_W'(prod);
    exp_ext = {1'b0, i_exp};
    frac_shift = 6'(FRAC_SHIFT);
    // The exponent moves the product by E minus the fixed fraction offset.
    if (exp_ext >= frac_shift)
    begin
      o_term = prod_ext <<< (exp_ext - frac_shift);
    end
    else
    begin
      o_term = prod_ext >>> (frac_shift - exp_ext);
    end
  end

endmodule // slg_gain_scale
`default_nettype wire

/* File: testbench/slg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module slg_host_model
(
  input wire logic i_core_clk,
  output logic o_hold_wr,
  output logic [1:0] o_hold_idx,
  output logic [7:0] o_hold_byte,
  output logic o_dest_wr,
  output logic [7:0] o_dest_addr
);
  initial
  begin
    o_hold_wr = 1'b0;
    o_hold_idx = 2'h0;
    o_hold_byte = 8'h00;
    o_dest_wr = 1'b0;
    o_dest_addr = 8'h00;
  end

  // Fills the four holding bytes, then moves the word to a destination.
  task automatic write_word(input logic [7:0] addr, input logic [31:0] word);
    logic [31:0] w;
    w = word;
    w[23:18] = 6'h00;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge i_core_clk);
      o_hold_wr = 1'b1;
      o_hold_idx = i[1:0];
      o_hold_byte = w[8*i +: 8];
    end
    @(negedge i_core_clk);
    o_hold_wr = 1'b0;
    o_hold_byte = ~o_hold_byte;
    o_dest_wr = 1'b1;
    o_dest_addr = addr;
    @(negedge i_core_clk);
    o_dest_wr = 1'b0;
    o_dest_addr = ~addr;
  endtask
endmodule // slg_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import slg_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic hold_wr;
  logic dest_wr;
  logic [1:0] hold_idx;
  logic [7:0] hold_byte;
  logic [7:0] dest_addr;
  logic track_mode = 1'b0;
  slg_err_type err = '0;
  slg_limit_type lim = '{upper: 32'h7fffffff, lower: 32'h80000000};
  logic [31:0] acq_gain;
  logic [31:0] trk_gain;
  logic [31:0] nco_word;
  logic pending;
  logic done;
  logic busy;
  logic nco_valid;
  logic [39:0] lag_acc;
  int n_errors = 0;
  int comparisons = 0;

  always #5 i_core_clk = ~i_core_clk;

  slg_host_model i_slg_host_model
  (
    .i_core_clk(i_core_clk),
    .o_hold_wr(hold_wr),
    .o_hold_idx(hold_idx),
    .o_hold_byte(hold_byte),
    .o_dest_wr(dest_wr),
    .o_dest_addr(dest_addr)
  );

  slg_symbol_loop i_slg_symbol_loop
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_hold_wr(hold_wr),
    .i_hold_idx(hold_idx),
    .i_hold_byte(hold_byte),
    .i_dest_wr(dest_wr),
    .i_dest_addr(dest_addr),
    .i_track_mode(track_mode),
    .i_err(err),
    .i_limit(lim),
    .o_acq_gain_reg(acq_gain),
    .o_trk_gain_reg(trk_gain),
    .o_lag_load_pending(pending),
    .o_lag_load_done(done),
    .o_calc_busy(busy),
    .o_lag_acc(lag_acc),
    .o_nco_word(nco_word),
    .o_nco_valid(nco_valid)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Runs one compute cycle and checks busy, the result pulse and the accumulator.
  task automatic run_compute(input logic [15:0] v, input logic [39:0] lag_first,
                             input logic [39:0] lag_end, input logic [31:0] nco);
    @(negedge i_core_clk);
    err = '{valid: 1'b1, value: v};
    @(negedge i_core_clk);
    err.valid = 1'b0;
    chk(lag_acc, lag_first);
    for (int k = 1; k <= 8; k++)
    begin
      chk(busy, 1'b1);
      @(negedge i_core_clk);
    end
    chk({busy, nco_valid}, 2'b01);
    chk(lag_acc, lag_end);
    chk(nco_word, nco);
  endtask

  task automatic test_gains();
    chk({acq_gain, trk_gain}, 64'h0);
    i_slg_host_model.write_word(8'h11, 32'hab00280c);
    i_slg_host_model.write_word(8'h12, 32'h5a03e9ec);
    i_slg_host_model.write_word(8'h20, 32'h0003ffff);
    chk(acq_gain, 32'h0000280c);
    chk(trk_gain, 32'h0003e9ec);
    $display("test_gains done");
  endtask

  task automatic test_modes();
    track_mode = 1'b0;
    run_compute(16'h0001, 40'h0, 40'h10, 32'h10);
    track_mode = 1'b1;
    run_compute(16'h0001, 40'h10, 40'h2f, 32'h1f);
    $display("test_modes done");
  endtask

  task automatic test_lag_init();
    lim.upper = 32'h00000005;
    i_slg_host_model.write_word(8'h13, 32'h00000005);
    chk(pending, 1'b1);
    // Holding registers are left alone until the load is done.
    repeat (3) @(negedge i_core_clk);
    chk({pending, done, lag_acc}, {2'b10, 40'h2f});
    run_compute(16'h0064, 40'h500, 40'h500, 32'hc21);
    chk({pending, done}, 2'b01);
    $display("test_lag_init done");
  endtask

  // Covers both shift directions, the lower clamp, a repeated load and a reset applied after the last compute has finished.
  task automatic test_scaling();
    lim.lower = 32'hfffffffd;
    track_mode = 1'b0;
    i_slg_host_model.write_word(8'h11, 32'h0002208e);
    chk(acq_gain, 32'h0002208e);
    run_compute(16'hff9c, 40'h500, 40'hfffffffd00, 32'hffffff67);
    i_slg_host_model.write_word(8'h13, 32'h00000002);
    chk({pending, done}, 2'b10);
    run_compute(16'h0000, 40'h200, 40'h200, 32'h2);
    chk({pending, done}, 2'b01);
    @(negedge i_core_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    chk({acq_gain, trk_gain}, 64'h0);
    chk({pending, done, busy, nco_valid, lag_acc}, 44'h0);
    chk(nco_word, 32'h0);
    $display("test_scaling done");
  endtask

  initial
  begin
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    test_gains();
    test_modes();
    test_lag_init();
    test_scaling();
    tally_and_finish();
  end

  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
